// [rtl/ibsaw_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ibsaw_top (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Special function register port
  input  wire logic [15:0] sfrAddr,
  input  wire logic        sfrWrEn,
  input  wire logic        sfrRdEn,
  input  wire logic [7:0]  sfrWrData,
  output logic      [7:0]  sfrRdData,
  // Serial clock pin
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  // Serial data pin
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Controls from the interface control logic
  input  wire logic        busEnable,
  input  wire logic        masterMode,
  input  wire logic        masterTx,
  input  wire logic        startRequest,
  input  wire logic        ackEnable,
  input  wire logic        eventClear,
  // Status toward the CPU and power control
  output logic             eventFlag,
  output logic      [7:0]  statusCode,
  output logic             wakeRequest
);
  // Reset release flops
  logic rstMeta_reg;
  logic rstN;

  // Release reset through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstN        <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN        <= rstMeta_reg;
    end
  end

  // Synchronised pin levels
  logic [ibsaw_pkg::PIN_COUNT-1:0] pinSync;
  wire logic sclS = pinSync[0];
  wire logic sdaS = pinSync[1];

  ibsaw_sync u_sync (
    .mclk    (mclk),
    .rstN    (rstN),
    .ce      (ce),
    .asyncIn ({sdaIn, sclIn}),
    .syncOut (pinSync)
  );

  // Registered state
  ibsaw_pkg::ibsaw_phase_t phase_reg;      // Byte phase of the frame
  logic                    sclPrev_reg;    // Previous clock level
  logic                    sdaPrev_reg;    // Previous data level
  logic [3:0]              bitCnt_reg;     // Rising edges in this byte
  logic [3:0]              slot_reg;       // Bit slot on the wire now
  logic                    addressed_reg;  // Selected as slave
  logic                    slaveRead_reg;  // Slave transmits
  logic                    arbLost_reg;    // Master lost, until mode drops
  logic                    arbPend_reg;    // Loss to report at byte end
  logic                    eventFlag_reg;  // Serial event flag
  logic [7:0]              status_reg;     // Status code
  logic                    wake_reg;       // Wake pulse
  logic [7:0]              ownAddr_reg;    // Own slave address
  logic [2:0]              wakeCtl_reg;    // Wake control bits
  logic [7:0]              rdData_reg;     // Read data
  logic                    sdaOe_reg;      // Pull data line low
  logic                    sclOe_reg;      // Hold clock line low
  logic                    pinLevel_reg;   // Level driven when enabled

  // Chain contents
  logic [7:0] shiftData;
  logic       shiftAck;
  logic       bufOut;

  // Bus condition detection
  wire logic sclRise = sclS && !sclPrev_reg;
  wire logic sclFall = !sclS && sclPrev_reg;
  wire logic startDet = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
  wire logic stopDet  = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
  wire logic inFrame  = phase_reg != ibsaw_pkg::PH_IDLE;

  // Master is ignored once arbitration is lost
  wire logic masterActive = masterMode && !arbLost_reg;

  // Shifting only while the event flag is clear
  wire logic shiftEn = inFrame && !eventFlag_reg;

  // Register decode
  wire logic selShift = sfrAddr == ibsaw_pkg::ADDR_SHIFT;
  wire logic selOwn   = sfrAddr == ibsaw_pkg::ADDR_OWN;
  wire logic selWake  = sfrAddr == ibsaw_pkg::ADDR_WAKE;

  // Data writes only outside active shifting
  wire logic cpuLoad = sfrWrEn && selShift && (eventFlag_reg || !inFrame);

  // Read selection, reserved wake bits read zero
  wire logic [7:0] wakeRead = {5'h00, wakeCtl_reg};
  wire logic [7:0] rdMux = selShift ? shiftData :
                           selOwn   ? ownAddr_reg :
                           selWake  ? wakeRead : 8'h00;

  // Byte events
  wire logic riseStep = sclRise && shiftEn;
  wire logic addrEval = riseStep && bitCnt_reg == 4'h7 && phase_reg == ibsaw_pkg::PH_ADDR;
  wire logic byteDone = riseStep && bitCnt_reg == ibsaw_pkg::ACK_SLOT;

  // Address byte as it stands after its eighth rise
  wire logic [7:0] addrNext = {shiftData[5:0], shiftAck, sdaS};

  // Address comparison, skipped when master or restarting
  wire logic slaveOk  = busEnable && !masterActive && !(arbLost_reg && startRequest);
  wire logic ownHit   = addrNext[7:1] == ownAddr_reg[7:1];
  wire logic gcHit    = addrNext == ibsaw_pkg::GENERAL_CALL && ownAddr_reg[ibsaw_pkg::GC_BIT];
  wire logic selfHit  = slaveOk && (ownHit || gcHit);

  // Wake on own address with enabled direction
  wire logic dirRead  = addrNext[0];
  wire logic wakeDir  = dirRead ? wakeCtl_reg[ibsaw_pkg::WAKE_RD] : wakeCtl_reg[ibsaw_pkg::WAKE_WR];
  wire logic wakeHit  = addrEval && slaveOk && ownHit && wakeCtl_reg[ibsaw_pkg::WAKE_GLOBAL] && wakeDir;

  // Who drives data bits this byte
  wire logic slaveTx = addressed_reg && slaveRead_reg && phase_reg == ibsaw_pkg::PH_DATA;
  wire logic transmitting = (masterActive && masterTx) || slaveTx;
  wire logic dataSlot = slot_reg < ibsaw_pkg::ACK_SLOT;
  wire logic ackSlot  = slot_reg == ibsaw_pkg::ACK_SLOT;

  // Arbitration lost: released line read low
  wire logic arbNow = riseStep && masterActive && masterTx && dataSlot && bufOut && !sdaS;

  // Acknowledge returned in the ninth slot
  wire logic ackAddr = phase_reg == ibsaw_pkg::PH_ADDR && addressed_reg;
  wire logic ackData = phase_reg == ibsaw_pkg::PH_DATA && (addressed_reg || masterActive) && ackEnable;
  wire logic rxAck   = ackSlot && !transmitting && (ackAddr || ackData);

  // Pull low for a zero bit or for an acknowledge
  wire logic sdaLowNext = inFrame && ((transmitting && dataSlot && !bufOut) || rxAck);

  // Event raised for a byte this device takes part in
  wire logic eventSet = byteDone && (addressed_reg || masterActive || arbPend_reg);

  ibsaw_shifter u_shifter (
    .mclk     (mclk),
    .rstN     (rstN),
    .ce       (ce),
    .sclRise  (sclRise),
    .sclFall  (sclFall),
    .sdaIn    (sdaS),
    .shiftEn  (shiftEn),
    .cpuLoad  (cpuLoad),
    .loadData (sfrWrData),
    .dataOut  (shiftData),
    .ackOut   (shiftAck),
    .bufOut   (bufOut)
  );

  // Edge history of the pins
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else if (ce) begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
    end
  end

  // Frame phase and bit counting
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      phase_reg  <= ibsaw_pkg::PH_IDLE;
      bitCnt_reg <= 4'h0;
      slot_reg   <= 4'h0;
    end else if (ce) begin
      if (startDet) begin
        phase_reg  <= ibsaw_pkg::PH_ADDR;
        bitCnt_reg <= 4'h0;
        slot_reg   <= 4'h0;
      end else if (stopDet) begin
        phase_reg <= ibsaw_pkg::PH_IDLE;
      end else if (riseStep) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
        if (byteDone) begin
          phase_reg <= ibsaw_pkg::PH_DATA;
        end
      end else if (sclFall && inFrame) begin
        // Ninth fall starts the next byte
        if (bitCnt_reg == ibsaw_pkg::LAST_RISE) begin
          bitCnt_reg <= 4'h0;
          slot_reg   <= 4'h0;
        end else begin
          slot_reg <= bitCnt_reg;
        end
      end
    end
  end

  // Slave selection and direction
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      addressed_reg <= 1'b0;
      slaveRead_reg <= 1'b0;
    end else if (ce) begin
      if (startDet || stopDet) begin
        addressed_reg <= 1'b0;
      end else if (addrEval) begin
        addressed_reg <= selfHit;
        slaveRead_reg <= dirRead;
      end
    end
  end

  // Arbitration loss tracking
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      arbLost_reg <= 1'b0;
      arbPend_reg <= 1'b0;
    end else if (ce) begin
      if (!masterMode) begin
        arbLost_reg <= 1'b0;
      end else if (arbNow) begin
        arbLost_reg <= 1'b1;
      end
      if (arbNow) begin
        arbPend_reg <= 1'b1;
      end else if (byteDone) begin
        arbPend_reg <= 1'b0;
      end
    end
  end

  // Event flag: a new event wins over a clear
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      eventFlag_reg <= 1'b0;
      status_reg    <= ibsaw_pkg::ST_NO_INFO;
    end else if (ce) begin
      eventFlag_reg <= eventSet || (eventFlag_reg && !eventClear);
      if (byteDone && arbPend_reg) begin
        status_reg <= ibsaw_pkg::ST_ARB_LOST;
      end else if (eventClear && !eventSet) begin
        status_reg <= ibsaw_pkg::ST_NO_INFO;
      end
    end
  end

  // Wake pulse toward power control
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wake_reg <= 1'b0;
    end else if (ce) begin
      wake_reg <= wakeHit;
    end
  end

  // CPU side registers, never changed by the bus
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ownAddr_reg <= ibsaw_pkg::RST_OWN;
      wakeCtl_reg <= ibsaw_pkg::RST_WAKE;
      rdData_reg  <= 8'h00;
    end else if (ce) begin
      if (sfrWrEn && selOwn) begin
        ownAddr_reg <= sfrWrData;
      end
      if (sfrWrEn && selWake) begin
        wakeCtl_reg <= sfrWrData[ibsaw_pkg::WAKE_BITS-1:0];
      end
      if (sfrRdEn) begin
        rdData_reg <= rdMux;
      end
    end
  end

  // Pin drive, changed only while the clock is low or outside a frame
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      sdaOe_reg    <= 1'b0;
      sclOe_reg    <= 1'b0;
      pinLevel_reg <= 1'b0;
    end else if (ce) begin
      if (!sclS || !inFrame) begin
        sdaOe_reg <= sdaLowNext && !arbNow;
      end
      // Stretch the clock so data stays stable
      sclOe_reg    <= eventFlag_reg && inFrame && (sclOe_reg || !sclS);
      pinLevel_reg <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign sfrRdData   = rdData_reg;
  assign sclOut      = pinLevel_reg;
  assign sclOe       = sclOe_reg;
  assign sdaOut      = pinLevel_reg;
  assign sdaOe       = sdaOe_reg;
  assign eventFlag   = eventFlag_reg;
  assign statusCode  = status_reg;
  assign wakeRequest = wake_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  a_data_stable_held: assert property (ce && eventFlag_reg && !cpuLoad |=> shiftData == $past(shiftData))
    else $error("Data changed while event flag set");
  a_own_addr_cpu: assert property (!(ce && sfrWrEn && selOwn) |=> ownAddr_reg == $past(ownAddr_reg))
    else $error("Own address changed without CPU write");
  a_match_selects: assert property (ce && addrEval && selfHit ##1 ce [*2] |=> eventFlag_reg || addressed_reg)
    else $error("Matching address not selected");
  a_gc_ignored: assert property (ce && addrEval && addrNext == 8'h00 && !ownAddr_reg[0]
      && ownAddr_reg[7:1] != 7'h00 |=> !addressed_reg)
    else $error("General call taken while disabled");
  a_wake_reserved: assert property (ce && sfrRdEn && selWake |=> rdData_reg[7:3] == 5'h00)
    else $error("Reserved wake bits not zero");
  a_wake_gate: assert property (wake_reg |-> $past(wakeCtl_reg[0]) && $past(addrEval))
    else $error("Wake without global enable or address");
  a_arb_release: assert property (ce && arbNow |=> arbLost_reg && arbPend_reg && !masterActive)
    else $error("Arbitration loss not taken");
  a_ack_ninth: assert property (ce && !sclS && inFrame && ackSlot && ackAddr && !transmitting
      && !arbNow |=> sdaOe_reg)
    else $error("Acknowledge not driven in ninth slot");
  a_event_on_done: assert property (ce && byteDone && addressed_reg |=> eventFlag_reg)
    else $error("Completed byte raised no event");
endmodule : ibsaw_top
`default_nettype wire

// [include/ibsaw_pkg.sv]
// What this block does
// - CPU data writes only while event flag set or outside a frame
// - Most significant bit first on the wire
// - Shift in bus level while shifting out
// - Bit equals bus level, shifts toward MSB
// - Data byte plus hidden ack bit chain
// - Sample on rise, ack in ninth pulse
// - Drive on fall, write preloads bit 7
// - Nine pulses send byte, capture ack
// - Own address only CPU written, master ignores
// - Own address match raises event flag
// - General call recognised when enable bit set
// - Wake bits: global, read, write enables
// - Wake bits 7 to 3 read zero
// - Arbitration loss releases bus, status 38h
package ibsaw_pkg;
  // Register offsets on the special function port
  localparam logic [15:0] ADDR_SHIFT = 16'h00da;
  localparam logic [15:0] ADDR_OWN   = 16'h00db;
  localparam logic [15:0] ADDR_WAKE  = 16'h610a;
  // Reset values
  localparam logic [7:0]  RST_SHIFT  = 8'h00;
  localparam logic [7:0]  RST_OWN    = 8'h00;
  localparam logic [2:0]  RST_WAKE   = 3'h0;
  // Wake control field positions
  localparam int          WAKE_GLOBAL = 0;
  localparam int          WAKE_RD     = 1;
  localparam int          WAKE_WR     = 2;
  localparam int          WAKE_BITS   = 3;
  // Own address field positions
  localparam int          GC_BIT      = 0;
  // Fixed bus values
  localparam logic [7:0]  GENERAL_CALL = 8'h00;
  localparam logic [7:0]  ST_ARB_LOST  = 8'h38;
  localparam logic [7:0]  ST_NO_INFO   = 8'hf8;
  // Bit slot counts in one byte frame
  localparam logic [3:0]  ACK_SLOT    = 4'h8;
  localparam logic [3:0]  LAST_RISE   = 4'h9;
  // Pins passing through the synchroniser
  localparam int          PIN_COUNT   = 2;
  // Byte phase of the frame
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} ibsaw_phase_t;
endpackage : ibsaw_pkg

// [rtl/ibsaw_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ibsaw_sync (
  // Clock, reset, enable
  input  wire logic                         mclk,
  input  wire logic                         rstN,
  input  wire logic                         ce,
  // Pin levels in and synchronised copies out
  input  wire logic [ibsaw_pkg::PIN_COUNT-1:0] asyncIn,
  output logic      [ibsaw_pkg::PIN_COUNT-1:0] syncOut
);
  // First stage, read only by the second
  logic [ibsaw_pkg::PIN_COUNT-1:0] stage1_reg;
  // Second stage, the one logic may read
  logic [ibsaw_pkg::PIN_COUNT-1:0] stage2_reg;

  // Two flops per pin, idle bus level is high
  for (genvar i = 0; i < ibsaw_pkg::PIN_COUNT; i++) begin : g_pin
    always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
        stage1_reg[i] <= 1'b1;
        stage2_reg[i] <= 1'b1;
      end else if (ce) begin
        stage1_reg[i] <= asyncIn[i];
        stage2_reg[i] <= stage1_reg[i];
      end
    end
  end

  assign syncOut = stage2_reg;
endmodule : ibsaw_sync
`default_nettype wire

// [rtl/ibsaw_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
module ibsaw_shifter (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rstN,
  input  wire logic       ce,
  // Bus events and level
  input  wire logic       sclRise,
  input  wire logic       sclFall,
  input  wire logic       sdaIn,
  // Shift permission and CPU load
  input  wire logic       shiftEn,
  input  wire logic       cpuLoad,
  input  wire logic [7:0] loadData,
  // Chain contents
  output logic      [7:0] dataOut,
  output logic            ackOut,
  output logic            bufOut
);
  logic [7:0] data_reg;  // Visible data byte
  logic       ack_reg;   // Hidden acknowledge stage
  logic       buf_reg;   // Output buffer toward the data line

  // Chain advance: bits enter via ack stage, move up
  wire logic [8:0] chainNext = {data_reg[6:0], ack_reg, sdaIn};
  wire logic       doRise    = shiftEn && sclRise;
  wire logic       doFall    = shiftEn && sclFall;

  // Load from CPU, else shift on the serial edges
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      data_reg <= ibsaw_pkg::RST_SHIFT;
      ack_reg  <= 1'b0;
      buf_reg  <= 1'b1;
    end else if (ce) begin
      if (cpuLoad) begin
        data_reg <= loadData;
        buf_reg  <= loadData[7];
      end else if (doRise) begin
        {data_reg, ack_reg} <= chainNext;
      end else if (doFall) begin
        buf_reg <= data_reg[7];
      end
    end
  end

  assign dataOut = data_reg;
  assign ackOut  = ack_reg;
  assign bufOut  = buf_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  a_load_first_bit: assert property (ce && cpuLoad |=> bufOut == $past(loadData[7]))
    else $error("Write did not preload bit 7");
  a_rise_chain_shift: assert property (ce && doRise && !cpuLoad
      |=> {dataOut, ackOut} == {$past(dataOut[6:0]), $past(ackOut), $past(sdaIn)})
    else $error("Chain did not shift toward the top");
  a_frozen_when_held: assert property (ce && !shiftEn && !cpuLoad
      |=> dataOut == $past(dataOut) && ackOut == $past(ackOut))
    else $error("Data moved while shifting was held");
endmodule : ibsaw_shifter
`default_nettype wire

// [verif/ibsaw_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module ibsaw_bus_master (
  // Open-drain enables from the device
  input  wire logic sclOe,
  input  wire logic sdaOe,
  // Resolved wire levels
  output logic      sclLine,
  output logic      sdaLine
);
  logic sclLow = 1'b0;  // Master pulls the clock low
  logic sdaLow = 1'b0;  // Master pulls the data low
  // Pull-ups: a released line goes high
  assign sclLine = ~(sclLow | sclOe);
  assign sdaLine = ~(sdaLow | sdaOe);
  // One 200 ns bit slot; data only changes while the clock is low
  task automatic bitSlot(input logic b, output logic r);
    sdaLow = ~b;
    #75 sclLow = 1'b0;
    // The device may stretch the clock low
    wait (sclLine === 1'b1);
    #35 r = sdaLine;
    #15 sclLow = 1'b1;
    #75;
  endtask : bitSlot
  // Start: data falls while the clock is high
  task automatic startCond();
    sdaLow = 1'b1;
    #100 sclLow = 1'b1;
    #50;
  endtask : startCond
  // Stop: data rises while the clock is high
  task automatic stopCond();
    sdaLow = 1'b1;
    #50 sclLow = 1'b0;
    wait (sclLine === 1'b1);
    #100 sdaLow = 1'b0;
    #100;
  endtask : stopCond
  // Eight bits MSB first, then the acknowledge slot
  task automatic byteSlot(input logic [7:0] d, input logic ackIn, output logic [7:0] seen, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitSlot(d[i], seen[i]);
    end
    bitSlot(ackIn, ack);
  endtask : byteSlot
endmodule : ibsaw_bus_master
`default_nettype wire

// [verif/i2c_byte_shift_address_wakeup_test.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_byte_shift_address_wakeup_test;
  // Clock, reset and register port drive
  logic        mclk       = 1'b0;
  logic        resetn     = 1'b0;
  logic [15:0] sfrAddr    = 16'h0000;
  logic        sfrWrEn    = 1'b0;
  logic        sfrRdEn    = 1'b0;
  logic [7:0]  sfrWrData  = 8'h00;
  logic        busEnable  = 1'b1;
  logic        ackEnable  = 1'b1;
  logic        eventClear = 1'b0;
  logic        ce         = 1'b1;
  logic        masterMode = 1'b0;
  logic        masterTx   = 1'b0;
  // Device outputs and resolved lines
  logic [7:0]  sfrRdData;
  logic [7:0]  statusCode;
  logic        sclOe, sdaOe, sclLine, sdaLine, eventFlag, wakeRequest;
  // Bookkeeping
  int          num_errors = 0;
  int          tests_run  = 0;
  int          wakeCount  = 0;
  int          wakeBase;
  logic [16:0] lfsr       = 17'h130fd;
  logic [6:0]  ownAddr;
  logic [7:0]  seen, txByte;
  logic        ack;

  // Design and bus master
  ibsaw_top ibsaw_top_i (.mclk(mclk), .resetn(resetn), .ce(ce), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sclIn(sclLine), .sclOut(),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .busEnable(busEnable), .masterMode(masterMode),
    .masterTx(masterTx), .startRequest(1'b0), .ackEnable(ackEnable), .eventClear(eventClear),
    .eventFlag(eventFlag), .statusCode(statusCode), .wakeRequest(wakeRequest));
  ibsaw_bus_master ibsaw_bus_master_i (.sclOe(sclOe), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));

  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // Count wake pulses
  always @(posedge mclk) begin
    if (wakeRequest === 1'b1) begin
      wakeCount <= wakeCount + 1;
    end
  end

  // Next pseudo-random state
  function automatic logic [16:0] lfsrNext(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsrNext
  // Expected wake for enables and direction
  function automatic logic wakeExp(input logic [2:0] w, input logic rw);
    return w[ibsaw_pkg::WAKE_GLOBAL] & (rw ? w[ibsaw_pkg::WAKE_RD] : w[ibsaw_pkg::WAKE_WR]);
  endfunction : wakeExp
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check
  // Register write, one strobe cycle
  task automatic sfrWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrAddr   <= a;
    sfrWrData <= d;
    sfrWrEn   <= 1'b1;
    @(posedge mclk);
    sfrWrEn   <= 1'b0;
  endtask : sfrWrite
  // Register read compared with an expectation
  task automatic readCheck(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge mclk);
    sfrRdEn <= 1'b0;
    #1 check(sfrRdData, exp);
  endtask : readCheck
  // One-cycle event clear
  task automatic pulseClear();
    @(posedge mclk);
    eventClear <= 1'b1;
    @(posedge mclk);
    eventClear <= 1'b0;
  endtask : pulseClear
  // Start plus an address byte, master leaves the ack slot free
  task automatic addrFrame(input logic [7:0] b);
    ibsaw_bus_master_i.startCond();
    ibsaw_bus_master_i.byteSlot(b, 1'b1, seen, ack);
  endtask : addrFrame
  // Release data, clear the event, stop
  task automatic endFrame();
    // The CPU only touches the data register while the flag is set
    if (eventFlag === 1'b1) begin
      sfrWrite(ibsaw_pkg::ADDR_SHIFT, 8'hff);
    end
    pulseClear();
    ibsaw_bus_master_i.stopCond();
    #400;
  endtask : endFrame
  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Hang guard
  initial begin
    #300000;
    num_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (5) @(posedge mclk);
    // Reset values and an unmapped place
    readCheck(ibsaw_pkg::ADDR_SHIFT, 8'h00);
    readCheck(ibsaw_pkg::ADDR_OWN, 8'h00);
    readCheck(ibsaw_pkg::ADDR_WAKE, 8'h00);
    readCheck(16'h0099, 8'h00);
    check(statusCode, ibsaw_pkg::ST_NO_INFO);
    // A write while the clock enable is low must not land
    @(posedge mclk);
    ce <= 1'b0;
    sfrWrite(ibsaw_pkg::ADDR_OWN, 8'h5a);
    ce <= 1'b1;
    readCheck(ibsaw_pkg::ADDR_OWN, 8'h00);
    $display("Test reset values done");
    // Own address match with a CPU write refused mid-byte
    lfsr = lfsrNext(lfsr);
    ownAddr = lfsr[6:0] | 7'h10;
    sfrWrite(ibsaw_pkg::ADDR_OWN, {ownAddr, 1'b0});
    readCheck(ibsaw_pkg::ADDR_OWN, {ownAddr, 1'b0});
    fork
      addrFrame({ownAddr, 1'b0});
      begin
        #700 sfrWrite(ibsaw_pkg::ADDR_SHIFT, ~{ownAddr, 1'b0});
      end
    join
    check({7'h00, ack}, 8'h00);
    check({7'h00, eventFlag}, 8'h01);
    readCheck(ibsaw_pkg::ADDR_SHIFT, {ownAddr, 1'b0});
    // Data byte from the master, acknowledge enable drawn at random
    lfsr = lfsrNext(lfsr);
    txByte = lfsr[7:0];
    pulseClear();
    ackEnable <= txByte[0];
    ibsaw_bus_master_i.byteSlot(txByte, 1'b1, seen, ack);
    check({7'h00, ack}, {7'h00, ~txByte[0]});
    check({7'h00, eventFlag}, 8'h01);
    readCheck(ibsaw_pkg::ADDR_SHIFT, txByte);
    endFrame();
    $display("Test address match done");
    // Foreign address is neither acknowledged nor flagged
    addrFrame({ownAddr ^ 7'h01, 1'b0});
    check({7'h00, ack}, 8'h01);
    check({7'h00, eventFlag}, 8'h00);
    endFrame();
    // General call honoured only with its enable bit
    for (int g = 1; g >= 0; g--) begin
      sfrWrite(ibsaw_pkg::ADDR_OWN, {ownAddr, g[0]});
      addrFrame(ibsaw_pkg::GENERAL_CALL);
      check({7'h00, eventFlag}, {7'h00, g[0]});
      endFrame();
    end
    readCheck(ibsaw_pkg::ADDR_OWN, {ownAddr, 1'b0});
    $display("Test foreign and general call done");
    // Slave transmit: preload on write, MSB first, bits shift back in
    lfsr = lfsrNext(lfsr);
    txByte = lfsr[7:0];
    addrFrame({ownAddr, 1'b1});
    check({7'h00, eventFlag}, 8'h01);
    sfrWrite(ibsaw_pkg::ADDR_SHIFT, txByte);
    pulseClear();
    ibsaw_bus_master_i.byteSlot(8'hff, 1'b1, seen, ack);
    check(seen, txByte);
    readCheck(ibsaw_pkg::ADDR_SHIFT, txByte);
    endFrame();
    $display("Test transmit done");
    // Master sends ones, loses on the first low bit, becomes addressed slave
    sfrWrite(ibsaw_pkg::ADDR_SHIFT, 8'hff);
    masterMode <= 1'b1;
    masterTx   <= 1'b1;
    addrFrame({ownAddr, 1'b0});
    check({7'h00, ack}, 8'h00);
    check({7'h00, eventFlag}, 8'h01);
    check(statusCode, ibsaw_pkg::ST_ARB_LOST);
    readCheck(ibsaw_pkg::ADDR_SHIFT, {ownAddr, 1'b0});
    endFrame();
    check(statusCode, ibsaw_pkg::ST_NO_INFO);
    @(posedge mclk);
    masterMode <= 1'b0;
    masterTx   <= 1'b0;
    $display("Test arbitration loss done");
    // Wake enables drawn at random, both directions
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsrNext(lfsr);
      sfrWrite(ibsaw_pkg::ADDR_WAKE, lfsr[7:0]);
      readCheck(ibsaw_pkg::ADDR_WAKE, {5'h00, lfsr[2:0]});
      wakeBase = wakeCount;
      addrFrame({ownAddr, lfsr[3]});
      endFrame();
      check(8'(wakeCount - wakeBase), {7'h00, wakeExp(lfsr[2:0], lfsr[3])});
    end
    $display("Test wake selection done");
    print_verdict();
  end
endmodule : i2c_byte_shift_address_wakeup_test
`default_nettype wire
